// ===== vts_pkg.sv
// constants and types shared by the vt supervision block
package vts_pkg;

    ////////////////////////////////////////////////////////////////////////
    // bus geometry
    localparam int ADDR_W = 5;                // byte address width
    localparam int DATA_W = 32;               // avalon data width
    localparam int MAG_W  = 16;               // magnitude width
    localparam int PCT_W  = 7;                // percent setting width
    localparam int IRQ_W  = 3;                // interrupt event count

    ////////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [4:0] OFS_CTRL     = 5'h00;
    localparam logic [4:0] OFS_VTHR     = 5'h04;
    localparam logic [4:0] OFS_ITHR     = 5'h08;
    localparam logic [4:0] OFS_LEVEL    = 5'h0C;
    localparam logic [4:0] OFS_STATUS   = 5'h10;
    localparam logic [4:0] OFS_IRQ_STAT = 5'h14;
    localparam logic [4:0] OFS_IRQ_MASK = 5'h18;

    ////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int CTRL_MODE_LSB = 0;         // two mode bits
    localparam int CTRL_DLD_EN   = 2;         // detector enable
    localparam int CTRL_DLD_BLK  = 3;         // detector block
    localparam int LO_LSB        = 0;         // low setting field
    localparam int HI_LSB        = 8;         // high setting field
    localparam int ST_FAIL       = 0;         // failure flag / event
    localparam int ST_DEAD       = 1;         // dead line flag / event
    localparam int ST_OK         = 2;         // line healthy / early clear

    ////////////////////////////////////////////////////////////////////////
    // setting ranges in percent
    localparam int VOLT_MIN  = 5;
    localparam int VOLT_MAX  = 50;
    localparam int CUR_MIN   = 10;
    localparam int CUR_MAX   = 50;
    localparam int LVL_V_MIN = 10;
    localparam int LVL_V_MAX = 100;
    localparam int LVL_I_MIN = 2;
    localparam int LVL_I_MAX = 100;

    ////////////////////////////////////////////////////////////////////////
    // comparator scaling and drop-out ratio 19/20
    localparam int MAG_PER_PCT = 10;          // magnitude lsb per percent
    localparam int HYST_NUM    = 19;
    localparam int HYST_DEN    = 20;

    ////////////////////////////////////////////////////////////////////////
    // timing
    localparam int FAIL_HOLD_MS  = 100;
    localparam int CLK_HZ        = 200_000_000;
    localparam int FAIL_HOLD_CYC = FAIL_HOLD_MS * (CLK_HZ / 1000);

    ////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [1:0] {
        MODE_OFF,
        MODE_ZERO,
        MODE_NEG,
        MODE_SPECIAL
    } vts_mode_e;

    typedef struct packed {
        logic [MAG_W-1:0] residual_voltage_mag;
        logic [MAG_W-1:0] residual_current_mag;
        logic [MAG_W-1:0] negseq_voltage_mag;
        logic [MAG_W-1:0] negseq_current_mag;
    } vts_mag_s;

    typedef struct packed {
        logic phase1_voltage_present;
        logic phase2_voltage_present;
        logic phase3_voltage_present;
        logic phase1_current_present;
        logic phase2_current_present;
        logic phase3_current_present;
    } vts_start_s;

    typedef struct packed {
        vts_mode_e        supervision_mode_select;
        logic             dld_enable;
        logic             dld_block;
        logic [PCT_W-1:0] residual_voltage_threshold;
        logic [PCT_W-1:0] negseq_voltage_threshold;
        logic [PCT_W-1:0] residual_current_threshold;
        logic [PCT_W-1:0] negseq_current_threshold;
        logic [PCT_W-1:0] line_voltage_level;
        logic [PCT_W-1:0] line_current_level;
    } vts_cfg_s;

    ////////////////////////////////////////////////////////////////////////
    // reset values
    localparam vts_cfg_s CFG_RST = '{
        supervision_mode_select    : MODE_ZERO,
        dld_enable                 : 1'b1,
        dld_block                  : 1'b0,
        residual_voltage_threshold : 7'h1E,
        negseq_voltage_threshold   : 7'h0A,
        residual_current_threshold : 7'h0A,
        negseq_current_threshold   : 7'h0A,
        line_voltage_level         : 7'h3C,
        line_current_level         : 7'h0A
    };
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

endpackage

// ===== vts_supervision.sv
// vt secondary circuit supervision with decision logic and avalon registers
//
// The register offsets and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none

// Function
// - inputs: sequence magnitudes, detector starts, settings
// - zero mode: residual v high, residual i low
// - negative mode: negseq v high, negseq i low
// - special: residual v high, both currents low
// - modes off/zero/neg/special, default zero
// - voltage thresholds 5..50, defaults 30, 10
// - current thresholds 10..50, both default 10
// - detector levels: voltage 10..100, current 2..100
// - works only with detector enabled, unblocked
// - user block input suppresses failure output
// - internal failure condition never leaves block
// - decision drives failure, dead, healthy flags
// - dead line: all voltages, currents low
// - healthy: all three voltages present
// - dead start clears failure younger 100 ms
module vts_supervision
    import vts_pkg::*;
#(
    parameter int FAIL_HOLD_CYCLES = FAIL_HOLD_CYC  // failure age limit
) (
    // clock and reset
    input  wire logic              mclk_in,
    input  wire logic              srst_in,
    // avalon-mm slave
    input  wire logic [ADDR_W-1:0] avs_address_in,
    input  wire logic              avs_read_in,
    input  wire logic              avs_write_in,
    input  wire logic [DATA_W-1:0] avs_writedata_in,
    input  wire logic [3:0]        avs_byteenable_in,
    output logic      [DATA_W-1:0] avs_readdata_out,
    output logic                   avs_waitrequest_out,
    // magnitudes and detector starts
    input  wire vts_mag_s          mag_in,
    input  wire logic              mag_valid_in,
    input  wire vts_start_s        start_in,
    input  wire logic              supervision_block_in,
    // detector levels toward the preparation stage
    output logic      [PCT_W-1:0]  line_voltage_level_out,
    output logic      [PCT_W-1:0]  line_current_level_out,
    // flags and interrupt
    output logic                   vt_failure_out,
    output logic                   dead_line_out,
    output logic                   line_healthy_out,
    output logic                   irq_out
);

    ////////////////////////////////////////////////////////////////////////
    // helper functions

    // threshold in magnitude units
    function automatic logic [23:0] pct_lvl(input logic [PCT_W-1:0] p);
        return 24'(p) * 24'(MAG_PER_PCT);
    endfunction

    // current below its threshold
    function automatic logic cur_low(input logic [MAG_W-1:0] m,
                                     input logic [PCT_W-1:0] p);
        return 24'(m) < pct_lvl(p);
    endfunction

    // voltage comparator with drop-out ratio
    function automatic logic volt_cmp(input logic             picked,
                                      input logic [MAG_W-1:0] m,
                                      input logic [PCT_W-1:0] p);
        logic [23:0] lvl;
        logic [23:0] mx;
        lvl = pct_lvl(p);
        mx  = 24'(m);
        if (picked) begin
            return !((mx * 24'(HYST_DEN)) < (lvl * 24'(HYST_NUM)));
        end
        return mx > lvl;
    endfunction

    // clamp a written percent into its range
    function automatic logic [PCT_W-1:0] clamp_pct(input logic [7:0] v,
                                                   input int lo,
                                                   input int hi);
        if (int'(v) < lo) begin
            return PCT_W'(lo);
        end
        if (int'(v) > hi) begin
            return PCT_W'(hi);
        end
        return v[PCT_W-1:0];
    endfunction

    localparam int HOLD_W = $clog2(FAIL_HOLD_CYCLES + 1);

    ////////////////////////////////////////////////////////////////////////
    // declarations

    logic              ack;             // answer cycle of a request
    logic              next_ack;
    logic [DATA_W-1:0] rdata;           // registered read data
    logic [DATA_W-1:0] next_rdata;
    logic [DATA_W-1:0] rd_mux;          // read data selection
    logic              req;             // read or write pending
    logic              wr_go;           // write takes effect
    logic              rd_go;           // read completes
    vts_cfg_s          cfg;             // settings
    vts_cfg_s          next_cfg;
    logic [IRQ_W-1:0]  irq_mask;        // interrupt mask
    logic [IRQ_W-1:0]  next_irq_mask;
    logic [IRQ_W-1:0]  irq_stat;        // sticky events
    logic [IRQ_W-1:0]  next_irq_stat;
    logic [IRQ_W-1:0]  irq_set;         // events this cycle
    logic              res_v_pick;      // residual voltage picked up
    logic              next_res_v_pick;
    logic              neg_v_pick;      // negseq voltage picked up
    logic              next_neg_v_pick;
    logic              fail_condition_internal;
    logic              next_fail_int;
    logic              fail;            // failure flag
    logic              next_fail;
    logic              dead;            // dead line flag
    logic              next_dead;
    logic              healthy;         // line healthy flag
    logic              next_healthy;
    logic              suppress;        // failure cleared by dead line
    logic              next_suppress;
    logic [HOLD_W-1:0] hold_cnt;        // cycles failure has stood
    logic [HOLD_W-1:0] next_hold_cnt;

    ////////////////////////////////////////////////////////////////////////
    // avalon slave: one wait cycle, answer on the second edge

    assign req                 = avs_read_in | avs_write_in;
    assign avs_waitrequest_out = req & ~ack;
    assign wr_go               = avs_write_in & ack;
    assign rd_go               = avs_read_in & ack;
    assign avs_readdata_out    = rdata;

    // read data selection, unmapped reads give zero
    always_comb begin
        rd_mux = '0;
        case (avs_address_in)
            OFS_CTRL: begin
                rd_mux[CTRL_MODE_LSB +: 2] = cfg.supervision_mode_select;
                rd_mux[CTRL_DLD_EN]        = cfg.dld_enable;
                rd_mux[CTRL_DLD_BLK]       = cfg.dld_block;
            end
            OFS_VTHR: begin
                rd_mux[LO_LSB +: PCT_W] = cfg.residual_voltage_threshold;
                rd_mux[HI_LSB +: PCT_W] = cfg.negseq_voltage_threshold;
            end
            OFS_ITHR: begin
                rd_mux[LO_LSB +: PCT_W] = cfg.residual_current_threshold;
                rd_mux[HI_LSB +: PCT_W] = cfg.negseq_current_threshold;
            end
            OFS_LEVEL: begin
                rd_mux[LO_LSB +: PCT_W] = cfg.line_voltage_level;
                rd_mux[HI_LSB +: PCT_W] = cfg.line_current_level;
            end
            OFS_STATUS: begin
                rd_mux[ST_FAIL] = fail;
                rd_mux[ST_DEAD] = dead;
                rd_mux[ST_OK]   = healthy;
            end
            OFS_IRQ_STAT: rd_mux[IRQ_W-1:0] = irq_stat;
            OFS_IRQ_MASK: rd_mux[IRQ_W-1:0] = irq_mask;
            default:      rd_mux = '0;
        endcase
    end

    // handshake and read capture
    always_comb begin
        next_ack   = req & ~ack;
        next_rdata = rdata;
        if (avs_read_in && !ack) begin
            next_rdata = rd_mux;
        end
    end

    // bus registers
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            ack   <= 1'b0;
            rdata <= '0;
        end else begin
            ack   <= next_ack;
            rdata <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // settings: writes clamp into the allowed ranges

    always_comb begin
        next_cfg      = cfg;
        next_irq_mask = irq_mask;
        if (wr_go) begin
            case (avs_address_in)
                OFS_CTRL: begin
                    if (avs_byteenable_in[0]) begin
                        next_cfg.supervision_mode_select =
                            vts_mode_e'(avs_writedata_in[CTRL_MODE_LSB +: 2]);
                        next_cfg.dld_enable = avs_writedata_in[CTRL_DLD_EN];
                        next_cfg.dld_block  = avs_writedata_in[CTRL_DLD_BLK];
                    end
                end
                OFS_VTHR: begin
                    if (avs_byteenable_in[0]) begin
                        next_cfg.residual_voltage_threshold = clamp_pct(
                            avs_writedata_in[7:0], VOLT_MIN, VOLT_MAX);
                    end
                    if (avs_byteenable_in[1]) begin
                        next_cfg.negseq_voltage_threshold = clamp_pct(
                            avs_writedata_in[15:8], VOLT_MIN, VOLT_MAX);
                    end
                end
                OFS_ITHR: begin
                    if (avs_byteenable_in[0]) begin
                        next_cfg.residual_current_threshold = clamp_pct(
                            avs_writedata_in[7:0], CUR_MIN, CUR_MAX);
                    end
                    if (avs_byteenable_in[1]) begin
                        next_cfg.negseq_current_threshold = clamp_pct(
                            avs_writedata_in[15:8], CUR_MIN, CUR_MAX);
                    end
                end
                OFS_LEVEL: begin
                    if (avs_byteenable_in[0]) begin
                        next_cfg.line_voltage_level = clamp_pct(
                            avs_writedata_in[7:0], LVL_V_MIN, LVL_V_MAX);
                    end
                    if (avs_byteenable_in[1]) begin
                        next_cfg.line_current_level = clamp_pct(
                            avs_writedata_in[15:8], LVL_I_MIN, LVL_I_MAX);
                    end
                end
                OFS_IRQ_MASK: begin
                    if (avs_byteenable_in[0]) begin
                        next_irq_mask = avs_writedata_in[IRQ_W-1:0];
                    end
                end
                default: next_cfg = cfg;   // read-only or unmapped
            endcase
        end
    end

    // settings registers, defaults at reset
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            cfg      <= CFG_RST;
            irq_mask <= IRQ_MASK_RST;
        end else begin
            cfg      <= next_cfg;
            irq_mask <= next_irq_mask;
        end
    end

    assign line_voltage_level_out = cfg.line_voltage_level;
    assign line_current_level_out = cfg.line_current_level;

    ////////////////////////////////////////////////////////////////////////
    // mode comparison, once per new magnitude set

    always_comb begin
        logic res_i_low;
        logic neg_i_low;
        res_i_low       = cur_low(mag_in.residual_current_mag,
                                  cfg.residual_current_threshold);
        neg_i_low       = cur_low(mag_in.negseq_current_mag,
                                  cfg.negseq_current_threshold);
        next_res_v_pick = res_v_pick;
        next_neg_v_pick = neg_v_pick;
        next_fail_int   = fail_condition_internal;
        if (mag_valid_in) begin
            next_res_v_pick = volt_cmp(res_v_pick, mag_in.residual_voltage_mag,
                                       cfg.residual_voltage_threshold);
            next_neg_v_pick = volt_cmp(neg_v_pick, mag_in.negseq_voltage_mag,
                                       cfg.negseq_voltage_threshold);
            case (cfg.supervision_mode_select)
                MODE_ZERO:    next_fail_int = next_res_v_pick & res_i_low;
                MODE_NEG:     next_fail_int = next_neg_v_pick & neg_i_low;
                MODE_SPECIAL: next_fail_int = next_res_v_pick & res_i_low
                                              & neg_i_low;
                default:      next_fail_int = 1'b0;
            endcase
        end
    end

    // comparator state, kept internal
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            res_v_pick              <= 1'b0;
            neg_v_pick              <= 1'b0;
            fail_condition_internal <= 1'b0;
        end else begin
            res_v_pick              <= next_res_v_pick;
            neg_v_pick              <= next_neg_v_pick;
            fail_condition_internal <= next_fail_int;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // decision logic

    always_comb begin
        logic det_on;
        logic allowed;
        logic v_any;
        logic i_any;
        logic young;
        det_on  = cfg.dld_enable & ~cfg.dld_block;
        allowed = det_on & ~supervision_block_in;
        v_any   = start_in.phase1_voltage_present
                | start_in.phase2_voltage_present
                | start_in.phase3_voltage_present;
        i_any   = start_in.phase1_current_present
                | start_in.phase2_current_present
                | start_in.phase3_current_present;
        young   = hold_cnt < HOLD_W'(FAIL_HOLD_CYCLES);
        next_dead    = det_on & ~v_any & ~i_any;
        next_healthy = det_on & start_in.phase1_voltage_present
                     & start_in.phase2_voltage_present
                     & start_in.phase3_voltage_present;
        // suppression lasts while the dead line stands
        next_suppress = suppress & next_dead;
        if (next_dead && !dead && fail && young) begin
            next_suppress = 1'b1;
        end
        next_fail = fail_condition_internal & allowed & ~next_suppress
                  & (cfg.supervision_mode_select != MODE_OFF);
        // age of the failure flag, saturating
        next_hold_cnt = '0;
        if (next_fail) begin
            next_hold_cnt = fail ? hold_cnt : HOLD_W'(1);
            if (fail && young) begin
                next_hold_cnt = hold_cnt + HOLD_W'(1);
            end
        end
    end

    // decision registers, inactive at reset
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            fail     <= 1'b0;
            dead     <= 1'b0;
            healthy  <= 1'b0;
            suppress <= 1'b0;
            hold_cnt <= '0;
        end else begin
            fail     <= next_fail;
            dead     <= next_dead;
            healthy  <= next_healthy;
            suppress <= next_suppress;
            hold_cnt <= next_hold_cnt;
        end
    end

    assign vt_failure_out   = fail;
    assign dead_line_out    = dead;
    assign line_healthy_out = healthy;

    ////////////////////////////////////////////////////////////////////////
    // interrupts: sticky events, read clears what was reported

    always_comb begin
        irq_set          = '0;
        irq_set[ST_FAIL] = next_fail & ~fail;
        irq_set[ST_DEAD] = next_dead & ~dead;
        irq_set[ST_OK]   = next_suppress & ~suppress;
        next_irq_stat    = irq_stat;
        if (rd_go && avs_address_in == OFS_IRQ_STAT) begin
            next_irq_stat = irq_stat & ~rdata[IRQ_W-1:0];
        end
        // a new event wins over the clear
        next_irq_stat = next_irq_stat | irq_set;
    end

    // interrupt status register
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            irq_stat <= '0;
        end else begin
            irq_stat <= next_irq_stat;
        end
    end

    assign irq_out = |(irq_stat & irq_mask);

endmodule // vts_supervision

`default_nettype wire

// ===== vts_monitor.sv
// port assertions for the vt supervision block
`timescale 1ns/100ps
`default_nettype none
module vts_monitor
    import vts_pkg::*;
(
    input wire logic             mclk_in,
    input wire logic             srst_in,
    input wire logic             avs_read_in,
    input wire logic             avs_write_in,
    input wire logic             avs_waitrequest_out,
    input wire vts_start_s       start_in,
    input wire logic             supervision_block_in,
    input wire logic [PCT_W-1:0] line_voltage_level_out,
    input wire logic [PCT_W-1:0] line_current_level_out,
    input wire logic             vt_failure_out,
    input wire logic             dead_line_out,
    input wire logic             line_healthy_out,
    input wire logic             irq_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (srst_in);
    ////////////////////////////////////////////////////////////////
    // bus request waiting in its first cycle
    sequence s_req;
        (avs_read_in || avs_write_in) && avs_waitrequest_out;
    endsequence
    property p_one_wait; s_req |=> !avs_waitrequest_out; endproperty
    a_one_wait: assert property (p_one_wait) else $error("bus wait longer than one cycle");
    property p_idle; !(avs_read_in || avs_write_in) |-> !avs_waitrequest_out; endproperty
    a_idle: assert property (p_idle) else $error("wait raised without request");
    ////////////////////////////////////////////////////////////////
    // flags tied to their causes one edge earlier, plus exclusion, level range and reset checks
    property p_block; $past(supervision_block_in) |-> !vt_failure_out; endproperty
    a_block: assert property (p_block) else $error("failure while user block active");
    property p_dead; dead_line_out |-> $past(start_in) == '0; endproperty
    a_dead: assert property (p_dead) else $error("dead line with a start present");
    property p_ok; line_healthy_out |-> &$past(start_in[5:3]); endproperty
    a_ok: assert property (p_ok) else $error("healthy without all voltages");
    property p_excl; !(dead_line_out && line_healthy_out); endproperty
    a_excl: assert property (p_excl) else $error("dead and healthy together");
    property p_levels;
        line_voltage_level_out inside {[10:100]} && line_current_level_out inside {[2:100]};
    endproperty
    a_levels: assert property (p_levels) else $error("level output out of range");
    property p_reset;
        disable iff (1'b0) srst_in |=> !(vt_failure_out || dead_line_out || line_healthy_out || irq_out);
    endproperty
    a_reset: assert property (p_reset) else $error("flags not cleared by reset");
endmodule // vts_monitor
bind vts_supervision vts_monitor u_mon (.mclk_in, .srst_in, .avs_read_in, .avs_write_in, .avs_waitrequest_out,
    .start_in, .supervision_block_in, .line_voltage_level_out, .line_current_level_out, .vt_failure_out,
    .dead_line_out, .line_healthy_out, .irq_out);
`default_nettype wire

// ===== vts_partner.sv
// downstream user logic model: registered supervision block request
`timescale 1ns/100ps
`default_nettype none
module vts_partner (
    input  wire logic mclk_in,
    input  wire logic block_req_in,
    output logic      supervision_block_out
);
    // user equation output changes on the clock, like any logic gate stage
    always_ff @(posedge mclk_in) begin
        supervision_block_out <= block_req_in;
    end
endmodule // vts_partner
`default_nettype wire

// ===== vt_circuit_supervision_bench.sv
// self-checking bench for the vt supervision block
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin miscompares++; \
    $display("mismatch %s exp %0h got %0h", n, e, g); end end
module vt_circuit_supervision_bench;
    import vts_pkg::*;
    logic mclk_in = 0, srst_in = 1, rd = 0, wr = 0, mv = 0, blk_req = 0, blk, wreq, fail, dead, ok, irq;
    logic [4:0] addr = '0;
    logic [3:0] be = 4'h3;
    logic [31:0] wdata = '0, rdata, q;
    logic [PCT_W-1:0] lv, lc;
    vts_mag_s mag = '0;
    vts_start_s st = 6'h3F;
    int miscompares = 0, checks_done = 0;
    initial forever #2.5 mclk_in = ~mclk_in;
    vts_partner u_part (.mclk_in(mclk_in), .block_req_in(blk_req), .supervision_block_out(blk));
    vts_supervision #(.FAIL_HOLD_CYCLES(20)) dut (.mclk_in(mclk_in), .srst_in(srst_in), .avs_address_in(addr),
        .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(be),
        .avs_readdata_out(rdata), .avs_waitrequest_out(wreq), .mag_in(mag), .mag_valid_in(mv), .start_in(st),
        .supervision_block_in(blk), .line_voltage_level_out(lv), .line_current_level_out(lc),
        .vt_failure_out(fail), .dead_line_out(dead), .line_healthy_out(ok), .irq_out(irq));
    ////////////////////////////////////////////////////////////////
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // one avalon access, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        rd <= !w;
        wr <= w;
        addr <= a;
        wdata <= d;
        do begin @(negedge mclk_in); n++; end while (wreq !== 1'b0 && n < 20);
        if (n >= 20) begin miscompares++; close_out(); end
        @(posedge mclk_in);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge mclk_in);
    endtask
    task automatic rdc(input logic [4:0] a, input logic [31:0] e);
        bus(1'b0, a, '0);
        `CHK("reg", e, q)
    endtask
    // flag and interrupt levels, looked at mid-cycle
    task automatic flags(input logic f, input logic d, input logic h, input logic i);
        @(negedge mclk_in);
        `CHK("fail", f, fail)
        `CHK("dead", d, dead)
        `CHK("healthy", h, ok)
        `CHK("irq", i, irq)
        @(posedge mclk_in);
    endtask
    // mode write, one magnitude set, expected failure flag
    task automatic step(input logic [1:0] m, input logic [15:0] a, b, c, d, input logic f);
        bus(1'b1, OFS_CTRL, {30'h1, m});
        mag <= '{a, b, c, d};
        mv <= 1'b1;
        @(posedge mclk_in);
        mv <= 1'b0;
        repeat (3) @(posedge mclk_in);
        flags(f, 1'b0, 1'b1, 1'b0);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge mclk_in);
        srst_in <= 1'b0;
        @(posedge mclk_in);
        rdc(OFS_CTRL, 32'h5);
        rdc(OFS_VTHR, 32'hA1E);
        rdc(OFS_ITHR, 32'hA0A);
        rdc(OFS_LEVEL, 32'hA3C);
        rdc(OFS_IRQ_MASK, 32'h0);
        rdc(5'h01, 32'h0);
        `CHK("vlevel", 7'h3C, lv)
        bus(1'b1, OFS_VTHR, 32'hFF02);
        rdc(OFS_VTHR, 32'h3205);
        bus(1'b1, OFS_ITHR, 32'h3309);
        rdc(OFS_ITHR, 32'h320A);
        bus(1'b1, OFS_LEVEL, 32'h0109);
        rdc(OFS_LEVEL, 32'h20A);
        `CHK("clevel", 7'h02, lc)
        bus(1'b1, OFS_VTHR, 32'hA1E);
        bus(1'b1, OFS_ITHR, 32'hA0A);
        bus(1'b1, OFS_LEVEL, 32'hA3C);
        step(2'd0, 400, 0, 400, 0, 1'b0);
        step(2'd1, 301, 99, 0, 0, 1'b1);
        step(2'd1, 286, 99, 0, 0, 1'b1);
        step(2'd1, 284, 99, 0, 0, 1'b0);
        step(2'd1, 300, 0, 0, 0, 1'b0);
        step(2'd1, 400, 100, 0, 0, 1'b0);
        step(2'd2, 0, 0, 100, 0, 1'b0);
        step(2'd2, 0, 0, 101, 99, 1'b1);
        step(2'd2, 0, 0, 101, 100, 1'b0);
        step(2'd3, 400, 0, 0, 100, 1'b0);
        step(2'd3, 400, 100, 0, 0, 1'b0);
        step(2'd3, 400, 0, 400, 99, 1'b1);
        bus(1'b1, OFS_IRQ_MASK, 32'h7);
        flags(1'b1, 1'b0, 1'b1, 1'b1);
        rdc(OFS_IRQ_STAT, 32'h1);
        rdc(OFS_IRQ_STAT, 32'h0);
        blk_req <= 1'b1;
        repeat (3) @(posedge mclk_in);
        flags(1'b0, 1'b0, 1'b1, 1'b0);
        blk_req <= 1'b0;
        repeat (3) @(posedge mclk_in);
        flags(1'b1, 1'b0, 1'b1, 1'b1);
        st <= '0;
        repeat (3) @(posedge mclk_in);
        flags(1'b0, 1'b1, 1'b0, 1'b1);
        rdc(OFS_IRQ_STAT, 32'h7);
        st <= 6'h3F;
        repeat (40) @(posedge mclk_in);
        st <= '0;
        repeat (3) @(posedge mclk_in);
        flags(1'b1, 1'b1, 1'b0, 1'b1);
        st <= 6'h38;
        repeat (3) @(posedge mclk_in);
        flags(1'b1, 1'b0, 1'b1, 1'b1);
        rdc(OFS_STATUS, 32'h5);
        st <= 6'h07;
        repeat (3) @(posedge mclk_in);
        flags(1'b1, 1'b0, 1'b0, 1'b1);
        bus(1'b1, OFS_CTRL, 32'h1);
        flags(1'b0, 1'b0, 1'b0, 1'b1);
        bus(1'b1, OFS_CTRL, 32'hD);
        flags(1'b0, 1'b0, 1'b0, 1'b1);
        be <= 4'h1;
        bus(1'b1, OFS_VTHR, 32'h1414);
        be <= 4'h3;
        rdc(OFS_VTHR, 32'hA14);
        close_out();
    end
endmodule // vt_circuit_supervision_bench
`default_nettype wire
